//--- rtl/bscc_top.v
// Dual buck switching-cycle control: frequency source, phase, references,
// protection. Assumes comparator and pin levels are asynchronous to clk and
// register writes arrive as a single-cycle strobe from the two-wire slave.
`timescale 1ns/10ps
`default_nettype none
`include "bscc_defines.vh"
// Summary of operation
// - External clock overrides resistor oscillator
// - First high level enters sync, releases pin
// - Sync cycle starts on clock falling edge
// - Lock to sync clock 200 to 1600 kHz
// - Lost sync: 100 kHz, then resistor rate
// - Soft-start ramp is target below reference
// - Internal divider after code written and apply
// - Code registers at offsets 0x00 and 0x01
// - Seven-bit code selects internal divider
// - Second channel starts half period later
// - Overvoltage holds high side off
// - Overvoltage persists until below 108 percent
// - Low gate drive forces low side on
// - Peak current ends high-side time
// - Sourcing limit skips next high-side pulse
// - Resume only when sourcing below limit
// - Sinking limit turns both off till cycle
// - Overload 512 cycles, hiccup 16384 cycles
// - Thermal stop, cool, count, restart
module bscc_top #(
   parameter HICCUP_TIME = `BSCC_HICCUP_TIME,  // Shorten for simulation
   parameter HICCUP_WAIT = `BSCC_HICCUP_WAIT,
   parameter RES_PERIOD  = `BSCC_RES_PERIOD    // Resistor-set period, clocks
) (
   // Clock and reset
   input  wire       clk,
   input  wire       arst_n,
   // Frequency-set pin (three-signal form)
   input  wire       freqSetIn,
   output reg        freqSetOut,
   output reg        freqSetOe,
   // Register write/read from two-wire slave
   input  wire       regWrite,
   input  wire [7:0] regAddr,
   input  wire [6:0] regWdata,
   input  wire       applyBit,
   output reg  [6:0] regRdata,
   // Analog comparators, per channel except the shared thermal pair
   input  wire [1:0] overVoltIn,
   input  wire [1:0] gateDriveLowIn,
   input  wire [1:0] peakHitIn,
   input  wire [1:0] lsSourceOverIn,
   input  wire [1:0] lsSinkOverIn,
   input  wire [1:0] overloadIn,
   input  wire [1:0] rampBelowRefIn,
   input  wire       overTempIn,
   input  wire       belowCoolIn,
   // Power stage and reference selection
   output reg  [1:0] highOn,
   output reg  [1:0] lowOn,
   output reg  [1:0] useRamp,
   output reg  [1:0] useInternal,
   output reg  [6:0] divCode1,
   output reg  [6:0] divCode2,
   output reg  [1:0] rampRestart,
   output reg        syncMode,
   output reg        syncLocked
);
   localparam NS = 15;  // Synchronised comparator and pin bits
   // Cycle figures held as 32-bit words; each use slices its own width
   localparam [31:0] RES_W  = RES_PERIOD;
   localparam [31:0] RES_L  = RES_PERIOD - 1;
   localparam [31:0] PMAX_W = `BSCC_PER_MAX;
   localparam [31:0] PMIN_L = `BSCC_PER_MIN - 1;
   localparam [31:0] SLOW_W = `BSCC_PER_FALLBACK;
   localparam [31:0] SLOW_L = `BSCC_PER_FALLBACK - 1;
   localparam [31:0] WAIT_L = HICCUP_WAIT - 1;  // Last overload sample
   localparam [31:0] HIC_L  = HICCUP_TIME - 1;  // Last hiccup cycle

   // Two-flop synchronisers for every asynchronous input
   reg [NS-1:0] syncA;
   reg [NS-1:0] syncB;
   wire [NS-1:0] rawIn = {freqSetIn, belowCoolIn, overTempIn, rampBelowRefIn,
      overloadIn, lsSinkOverIn, lsSourceOverIn, peakHitIn, overVoltIn};
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         syncA <= {NS{1'b0}};
         syncB <= {NS{1'b0}};
      end else begin
         syncA <= rawIn;
         syncB <= syncA;
      end
   end
   wire [1:0] sOv    = syncB[1:0];
   wire [1:0] sPeak  = syncB[3:2];
   wire [1:0] sSrc   = syncB[5:4];
   wire [1:0] sSink  = syncB[7:6];
   wire [1:0] sOvld  = syncB[9:8];
   wire [1:0] sRamp  = syncB[11:10];
   wire       sHot   = syncB[12];
   wire       sCool  = syncB[13];
   wire       sFreq  = syncB[14];
   wire [1:0] sGdl;  // Gate-drive low passes its own pair below
   reg  [1:0] gdA;
   reg  [1:0] gdB;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gdA <= 2'h0;
         gdB <= 2'h0;
      end else begin
         gdA <= gateDriveLowIn;
         gdB <= gdA;
      end
   end
   assign sGdl = gdB;

   // Rising- and falling-edge detect on synchronised pin level
   reg freqPrev;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) freqPrev <= 1'b0;
      else freqPrev <= sFreq;
   end
   wire freqFall = freqPrev & ~sFreq;
   wire freqRise = ~freqPrev & sFreq;

   // Frequency source state machine
   localparam ST_RES  = 2'h0;  // Resistor-set oscillator
   localparam ST_SYNC = 2'h1;  // Following external clock
   localparam ST_SLOW = 2'h2;  // Fallback rate after clock loss
   reg  [1:0]  fsState;
   reg  [11:0] perCnt;    // Clocks since last cycle start
   reg  [11:0] period;    // Current switching period, clocks
   reg  [11:0] slowCnt;   // Fallback cycles remaining
   reg         cycStart;  // Channel-1 cycle start pulse
   wire        perMax = (perCnt >= PMAX_W[11:0]);
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fsState    <= ST_RES;
         perCnt     <= 12'h000;
         period     <= RES_W[11:0];
         slowCnt    <= 12'h000;
         cycStart   <= 1'b0;
         syncMode   <= 1'b0;
         syncLocked <= 1'b0;
         freqSetOut <= 1'b0;
         freqSetOe  <= 1'b0;
      end else begin
         cycStart   <= 1'b0;
         freqSetOut <= 1'b0;
         perCnt     <= perCnt + 12'h001;
         case (fsState)
            ST_RES: begin
               syncMode  <= 1'b0;
               freqSetOe <= 1'b0;  // Resistor only; never driven
               if (freqRise) begin
                  fsState  <= ST_SYNC;  // First high level
                  syncMode <= 1'b1;     // Overrides resistor
                  perCnt   <= 12'h000;
               end else if (perCnt >= RES_L[11:0]) begin
                  perCnt   <= 12'h000;
                  period   <= RES_W[11:0];
                  cycStart <= 1'b1;
               end
            end
            ST_SYNC: begin
               freqSetOe <= 1'b0;  // Pin left high impedance
               if (freqFall) begin
                  cycStart <= 1'b1;  // Cycle on falling edge
                  perCnt   <= 12'h000;
                  period   <= perCnt + 12'h001;
                  // Lock flag only for in-range periods
                  syncLocked <= (perCnt >= PMIN_L[11:0])
                     && !perMax;
               end else if (perMax) begin
                  // Clock lost: fall to fixed low rate
                  fsState    <= ST_SLOW;
                  syncMode   <= 1'b0;
                  syncLocked <= 1'b0;
                  slowCnt    <= `BSCC_FALLBACK_CYCLES;
                  period     <= SLOW_W[11:0];
                  perCnt     <= 12'h000;
               end
            end
            ST_SLOW: begin
               if (perCnt >= SLOW_L[11:0]) begin
                  perCnt   <= 12'h000;
                  cycStart <= 1'b1;
                  slowCnt  <= slowCnt - 12'h001;
                  if (slowCnt == 12'h001) begin
                     fsState <= ST_RES;  // Then resistor rate
                     period  <= RES_W[11:0];
                  end
               end
            end
            default: fsState <= ST_RES;
         endcase
      end
   end

   // Half-period delayed start for channel 2
   reg [11:0] halfCnt;
   reg        halfArm;
   reg        cycStart2;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         halfCnt   <= 12'h000;
         halfArm   <= 1'b0;
         cycStart2 <= 1'b0;
      end else begin
         cycStart2 <= 1'b0;
         if (cycStart) begin
            halfCnt <= {1'b0, period[11:1]};
            halfArm <= 1'b1;
         end else if (halfArm) begin
            // Fire at two: the load edge already spent one clock
            if (halfCnt <= 12'h002) begin
               halfArm   <= 1'b0;
               cycStart2 <= 1'b1;
            end else begin
               halfCnt <= halfCnt - 12'h001;
            end
         end
      end
   end
   wire [1:0] chStart = {cycStart2, cycStart};

   // Voltage-code registers and divider selection
   reg [6:0] code1;
   reg [6:0] code2;
   reg [1:0] written;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         code1       <= `BSCC_CODE_RST;
         code2       <= `BSCC_CODE_RST;
         written     <= 2'h0;
         useInternal <= 2'h0;
         divCode1    <= `BSCC_CODE_RST;
         divCode2    <= `BSCC_CODE_RST;
         regRdata    <= 7'h00;
      end else begin
         if (regWrite && regAddr == `BSCC_OFS_CODE1) begin
            code1      <= regWdata;  // Seven-bit code
            written[0] <= 1'b1;
         end
         if (regWrite && regAddr == `BSCC_OFS_CODE2) begin
            code2      <= regWdata;
            written[1] <= 1'b1;
         end
         // Apply bit moves written codes to the divider
         if (applyBit) begin
            useInternal <= useInternal | written;
            if (written[0]) divCode1 <= code1;
            if (written[1]) divCode2 <= code2;
         end
         // Unmapped offsets read zero
         if (regAddr == `BSCC_OFS_CODE1) regRdata <= code1;
         else if (regAddr == `BSCC_OFS_CODE2) regRdata <= code2;
         else regRdata <= 7'h00;
      end
   end

   // Overvoltage comparator already has 108 percent release
   // Overload and thermal hiccup control, counted per cycle
   localparam PR_RUN  = 2'h0;
   localparam PR_HIC  = 2'h1;  // Overload hiccup wait
   localparam PR_HOT  = 2'h2;  // Over-temperature stop
   localparam PR_COOL = 2'h3;  // Thermal hiccup count
   reg [1:0]  prState;
   reg [9:0]  ovldCnt;
   reg [14:0] hicCnt;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prState     <= PR_RUN;
         ovldCnt     <= 10'h000;
         hicCnt      <= 15'h0000;
         rampRestart <= 2'h0;
      end else begin
         rampRestart <= 2'h0;
         if (sHot && prState != PR_HOT) begin
            prState <= PR_HOT;  // Stop switching
         end else begin
            case (prState)
               PR_RUN: if (cycStart) begin  // Per switching cycle
                  if (|sOvld) begin
                     if (ovldCnt >= WAIT_L[9:0]) begin
                        prState <= PR_HIC;
                        hicCnt  <= 15'h0000;
                     end
                     ovldCnt <= ovldCnt + 10'h001;
                  end else begin
                     ovldCnt <= 10'h000;
                  end
               end
               PR_HIC, PR_COOL: if (cycStart) begin
                  if (hicCnt >= HIC_L[14:0]) begin
                     prState     <= PR_RUN;
                     ovldCnt     <= 10'h000;
                     rampRestart <= 2'h3;  // Fresh soft start
                  end else begin
                     hicCnt <= hicCnt + 15'h0001;
                  end
               end
               PR_HOT: if (sCool && !sHot) begin
                  prState <= PR_COOL;  // Start thermal count
                  hicCnt  <= 15'h0000;
               end
               default: prState <= PR_RUN;
            endcase
         end
      end
   end
   wire running = (prState == PR_RUN);

   // Feedback target selection
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) useRamp <= 2'h3;
      else useRamp <= sRamp;
   end

   // Two channels; outputs re-registered
   wire [1:0] chHigh;
   wire [1:0] chLow;
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : gCh
         bscc_channel uCh (
            .clk          (clk),
            .arst_n       (arst_n),
            .cycleStart   (chStart[g]),
            .run          (running),
            .overVolt     (sOv[g]),
            .gateDriveLow (sGdl[g]),
            .peakHit      (sPeak[g]),
            .lsSourceOver (sSrc[g]),
            .lsSinkOver   (sSink[g]),
            .highOn       (chHigh[g]),
            .lowOn        (chLow[g])
         );
      end
   endgenerate
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         highOn <= 2'h0;
         lowOn  <= 2'h0;
      end else begin
         highOn <= chHigh & {2{running}};
         lowOn  <= chLow & {2{running}};
      end
   end
endmodule // bscc_top
`default_nettype wire

//--- rtl/bscc_defines.vh
// Constants for the dual buck switching-cycle control block.
// Included by bare name; definitions only.
`ifndef BSCC_DEFINES_VH
`define BSCC_DEFINES_VH
// Register offsets (voltage-code registers)
`define BSCC_OFS_CODE1      8'h00
`define BSCC_OFS_CODE2      8'h01
`define BSCC_CODE_W         7
`define BSCC_CODE_RST       7'h00
// Clock and frequency figures
`define BSCC_CLK_KHZ        25000
`define BSCC_FSYNC_MIN_KHZ  200
`define BSCC_FSYNC_MAX_KHZ  1600
`define BSCC_FALLBACK_KHZ   100
// Resistor-set period in clocks, and fallback cycles before it returns
`define BSCC_RES_PERIOD     50
`define BSCC_FALLBACK_CYCLES 12'h008
// Cycle counts derived from the figures (round down / up)
`define BSCC_PER_MAX  (`BSCC_CLK_KHZ / `BSCC_FSYNC_MIN_KHZ)
`define BSCC_PER_MIN  ((`BSCC_CLK_KHZ + `BSCC_FSYNC_MAX_KHZ - 1) / `BSCC_FSYNC_MAX_KHZ)
`define BSCC_PER_FALLBACK (`BSCC_CLK_KHZ / `BSCC_FALLBACK_KHZ)
// Protection counts in switching cycles
`define BSCC_HICCUP_WAIT    512
`define BSCC_HICCUP_TIME    16384
`endif

//--- rtl/bscc_channel.v
// One buck channel's switching-cycle state machine.
// Assumes comparator inputs are already synchronised to clk.
`timescale 1ns/10ps
`default_nettype none
module bscc_channel (
   // Clock and reset
   input  wire       clk,
   input  wire       arst_n,
   // Cycle timing
   input  wire       cycleStart,
   input  wire       run,
   // Comparators
   input  wire       overVolt,
   input  wire       gateDriveLow,
   input  wire       peakHit,
   input  wire       lsSourceOver,
   input  wire       lsSinkOver,
   // Drives
   output reg        highOn,
   output reg        lowOn
);
   reg skipHigh;   // Sourcing limit latched at cycle end
   reg sinkOff;    // Sink limit tripped this cycle
   // Per-cycle switch control
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         highOn   <= 1'b0;
         lowOn    <= 1'b0;
         skipHigh <= 1'b0;
         sinkOff  <= 1'b0;
      end else if (!run) begin
         // Both off while stopped
         highOn   <= 1'b0;
         lowOn    <= 1'b0;
         skipHigh <= 1'b0;
         sinkOff  <= 1'b0;
      end else if (cycleStart) begin
         // Source limit sampled at cycle edge
         skipHigh <= lsSourceOver;
         sinkOff  <= 1'b0;
         if (lsSourceOver || overVolt || gateDriveLow) begin
            highOn <= 1'b0;
            lowOn  <= 1'b1;
         end else begin
            highOn <= 1'b1;  // Resume when under limit
            lowOn  <= 1'b0;
         end
      end else if (highOn && (peakHit || overVolt || gateDriveLow)) begin
         // Peak hit, overvoltage or recharge need
         highOn   <= 1'b0;
         lowOn    <= 1'b1;   // Recharge gate-drive capacitor
      end else if (lowOn && lsSinkOver) begin
         lowOn   <= 1'b0;    // Both off to cycle end
         sinkOff <= 1'b1;
      end else if (!highOn && !lowOn && !sinkOff) begin
         lowOn <= 1'b1;      // Idle low side conducts
      end
   end
endmodule // bscc_channel
`default_nettype wire

//--- tb/bscc_properties.sv
// Port-level checker for the switching-cycle control top.
// Bound into bscc_top; inputs change on falling clock edges.
`timescale 1ns/10ps
`default_nettype none
module bscc_properties (
   // Clock and reset
   input wire logic       clk,
   input wire logic       arst_n,
   // Register side
   input wire logic       regWrite,
   input wire logic       applyBit,
   input wire logic [7:0] regAddr,
   input wire logic [6:0] regWdata,
   input wire logic [6:0] regRdata,
   input wire logic [6:0] divCode1,
   input wire logic [1:0] useInternal,
   // Comparators
   input wire logic [1:0] overVoltIn,
   input wire logic [1:0] gateDriveLowIn,
   input wire logic [1:0] rampBelowRefIn,
   input wire logic       overTempIn,
   // Drives
   input wire logic       freqSetOe,
   input wire logic [1:0] highOn,
   input wire logic [1:0] lowOn,
   input wire logic [1:0] useRamp,
   input wire logic [1:0] rampRestart
);
   // Five samples cover the four-cycle path from pin to drive
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_pin_released: assert property (!freqSetOe)
      else $error("frequency pin driven");
   a_overvolt_hold: assert property (
      overVoltIn[0] [*5] |-> !highOn[0])
      else $error("high side on in overvoltage");
   a_gdl_recharge: assert property (
      gateDriveLowIn[0] [*5] |-> !highOn[0] && lowOn[0])
      else $error("no recharge on low gate drive");
   a_thermal_off: assert property (
      overTempIn [*5] |-> highOn == 2'b00 && lowOn == 2'b00)
      else $error("switching while hot");
   a_unmapped_zero: assert property (
      (regAddr > 8'h01) [*2] |-> regRdata == 7'h00)
      else $error("unmapped read not zero");
   a_apply_internal: assert property (
      regWrite && regAddr == 8'h00 ##1 applyBit |=>
      useInternal[0] && divCode1 == $past(regWdata, 2))
      else $error("apply did not select code");
   a_ramp_target: assert property (
      rampBelowRefIn[0] [*5] |-> useRamp[0])
      else $error("ramp not used as target");
   a_restart_pulse: assert property (
      rampRestart[0] |-> !highOn[0] ##1 !rampRestart[0])
      else $error("restart pulse malformed");
endmodule // bscc_properties
bind bscc_top bscc_properties bscc_properties_inst (
   .clk, .arst_n, .regWrite, .applyBit, .regAddr, .regWdata,
   .regRdata, .divCode1, .useInternal, .overVoltIn, .gateDriveLowIn,
   .rampBelowRefIn, .overTempIn, .freqSetOe, .highOn, .lowOn,
   .useRamp, .rampRestart);
`default_nettype wire

//--- tb/bscc_partner.sv
// Far-side model: external sync clock and peak-current comparators.
// Assumes the bench drives syncEn; all changes on the falling edge.
`timescale 1ns/10ps
`default_nettype none
module bscc_partner #(
   parameter int HALF = 10, // Sync half period, clocks
   parameter int PEAK = 6   // High-side clocks until peak current
) (
   // Clock and control
   input  wire logic       clk,
   input  wire logic       syncEn,
   input  wire logic [1:0] highOn,
   // Pin and comparator levels
   output var  logic       freqSetIn,
   output var  logic [1:0] peakHitIn
);
   int ph = 0;             // Position in the sync half period
   int hs [2] = '{0, 0};   // Conduction time per channel
   initial begin
      freqSetIn = 1'b0;
      peakHitIn = 2'b00;
   end
   // Square wave, 50 percent duty; pin resistor pulls low when idle
   always @(negedge clk) begin
      ph <= (syncEn && ph < HALF - 1) ? ph + 1 : 0;
      if (!syncEn)
         freqSetIn <= 1'b0;
      else if (ph == HALF - 1)
         freqSetIn <= !freqSetIn;
   end
   // Current ramps while the high side conducts, trips after PEAK
   always @(negedge clk) begin
      for (int i = 0; i < 2; i++) begin
         hs[i] <= highOn[i] ? hs[i] + 1 : 0;
         peakHitIn[i] <= highOn[i] && hs[i] >= PEAK - 1;
      end
   end
endmodule // bscc_partner
`default_nettype wire

//--- tb/tb_top.sv
// Testbench: registers, switching timing and protection of bscc_top.
// Assumes the partner model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int RP = 50; // Resistor period, clocks
   localparam int SH = 10; // Sync half period, clocks
   localparam int HT = 8;  // Shortened hiccup time, cycles
   localparam int HW = 4;  // Shortened hiccup wait, cycles
   // Stimulus, all changed on falling edges
   logic       clk = 1'b0, arst_n = 1'b0, syncEn = 1'b0;
   logic       regWrite = 1'b0, applyBit = 1'b0;
   logic       overTemp = 1'b0, cool = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [6:0] regWdata = 7'h00;
   logic [1:0] flt [3] = '{2'b00, 2'b00, 2'b00}; // Overvolt, gate, source
   logic [1:0] sink = 2'b00, ovl = 2'b00, ramp = 2'b11;
   // Observed
   logic       pinLvl, freqPin, freqSetOut, freqSetOe;
   logic       syncMode, syncLocked;
   logic [6:0] regRdata, divCode1, divCode2;
   logic [1:0] highOn, lowOn, useRamp, useInternal, rampRestart;
   logic [1:0] peakHit;
   int         fail_count = 0;
   int         checks_done = 0;
   // Pin level from the DUT's enable; partner drives it otherwise
   assign freqPin = freqSetOe ? freqSetOut : pinLvl;
   bscc_top #(.HICCUP_TIME(HT), .HICCUP_WAIT(HW), .RES_PERIOD(RP))
      bscc_top_inst (.clk, .arst_n, .freqSetIn(freqPin), .freqSetOut,
      .freqSetOe, .regWrite, .regAddr, .regWdata, .applyBit, .regRdata,
      .overVoltIn(flt[0]), .gateDriveLowIn(flt[1]), .peakHitIn(peakHit),
      .lsSourceOverIn(flt[2]), .lsSinkOverIn(sink), .overloadIn(ovl),
      .rampBelowRefIn(ramp), .overTempIn(overTemp), .belowCoolIn(cool),
      .highOn, .lowOn, .useRamp, .useInternal, .divCode1, .divCode2,
      .rampRestart, .syncMode, .syncLocked);
   bscc_partner #(.HALF(SH), .PEAK(6)) bscc_partner_inst (.clk,
      .syncEn, .highOn, .freqSetIn(pinLvl), .peakHitIn(peakHit));
   initial forever #20 clk = ~clk; // 25 MHz
   // Watchdog, several times the expected run
   initial begin
      repeat (30000) @(posedge clk);
      fail_count++;
      final_report();
   end
   task tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Range compare; an unknown never passes
   task chk(input string nm, input int lo, hi, input logic [31:0] v);
      checks_done++;
      if ((v >= lo && v <= hi) !== 1'b1) begin
         fail_count++;
         $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, v);
      end
   endtask
   // Write strobe stands one cycle
   task wr(input logic [7:0] a, input logic [6:0] d);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      tick(1);
      regWrite = 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [6:0] e);
      regAddr = a;
      tick(2);
      chk("regRdata", e, e, regRdata);
   endtask
   // Cycles until the next high-side turn-on of channel c
   task rise(input int c, output int t);
      t = 0;
      while (highOn[c] !== 1'b0 && t < 3000) begin
         tick(1);
         t++;
      end
      while (highOn[c] !== 1'b1 && t < 3000) begin
         tick(1);
         t++;
      end
   endtask
   task gap(input string nm, input int a, b, lo, hi);
      int t;
      rise(a, t);
      rise(b, t);
      chk(nm, lo, hi, t);
   endtask
   // Turn-ons of the first channel over n cycles
   task cnt(input string nm, input int n, lo, hi);
      int k;
      logic p;
      k = 0;
      p = highOn[0];
      repeat (n) begin
         tick(1);
         k += (highOn[0] === 1'b1 && p !== 1'b1);
         p = highOn[0];
      end
      chk(nm, lo, hi, k);
   endtask
   task pulse(input string nm, input int lo, hi);
      int t;
      t = 0;
      while (rampRestart[0] !== 1'b1 && t < 3000) begin
         tick(1);
         t++;
      end
      chk(nm, lo, hi, t);
      chk("rampRestart", 3, 3, rampRestart);
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      tick(5);
      chk("useRamp", 3, 3, useRamp);
      chk("highOn", 0, 0, highOn);
      arst_n = 1'b1;
      tick(2);
      wr(8'h01, 7'h2a);
      tick(1);
      wr(8'h00, 7'h55);
      chk("useInternal", 0, 0, useInternal);
      applyBit = 1'b1;
      tick(1);
      applyBit = 1'b0;
      tick(1);
      chk("useInternal", 3, 3, useInternal);
      chk("divCode1", 7'h55, 7'h55, divCode1);
      chk("divCode2", 7'h2a, 7'h2a, divCode2);
      rd(8'h00, 7'h55);
      rd(8'h01, 7'h2a);
      rd(8'h07, 7'h00);
      ramp = 2'b00;
      tick(6);
      chk("useRamp", 0, 0, useRamp);
      gap("period", 0, 0, RP, RP);
      gap("phase", 0, 1, RP / 2 - 1, RP / 2 + 1);
      $display("registers and resistor mode done");
      syncEn = 1'b1;
      tick(200);
      chk("syncMode", 1, 1, syncMode);
      chk("syncLocked", 1, 1, syncLocked);
      chk("pin driven", 0, 0, {freqSetOut, freqSetOe});
      gap("sync period", 0, 0, 2 * SH, 2 * SH);
      gap("sync phase", 0, 1, SH - 1, SH + 1);
      syncEn = 1'b0;
      tick(200);
      gap("fallback", 0, 0, 25000 / 100, 25000 / 100);
      chk("syncMode", 0, 0, syncMode);
      tick(2000);
      gap("resistor again", 0, 0, RP, RP);
      $display("sync done");
      for (int f = 0; f < 3; f++) begin
         flt[f] = 2'b01;
         tick(4);
         cnt("fault", 200, 0, 0);
         chk("lowOn", 1, 1, lowOn[0]);
         flt[f] = 2'b00;
         cnt("resume", 200, 3, 4);
      end
      gap("sink align", 0, 0, RP, RP);
      tick(12);
      sink = 2'b01;
      tick(4);
      chk("sink both", 0, 0, {highOn[0], lowOn[0]});
      sink = 2'b00;
      tick(10);
      chk("sink hold", 0, 0, lowOn[0]);
      cnt("sink next", 100, 2, 2);
      ovl = 2'b01;
      tick((HW + 2) * RP);
      cnt("hiccup off", (HT - 3) * RP, 0, 0);
      pulse("hiccup end", 1, 3 * RP);
      ovl = 2'b00;
      overTemp = 1'b1;
      cool = 1'b0;
      tick(10);
      cnt("hot", 200, 0, 0);
      overTemp = 1'b0;
      cnt("warm", 200, 0, 0);
      cool = 1'b1;
      pulse("cool", (HT - 1) * RP, (HT + 1) * RP);
      cnt("restart", 200, 3, 4);
      $display("protection done");
      final_report();
   end
endmodule // tb_top
`default_nettype wire
